// ===== rtl/ext_decode_pkg.sv
// package: constants, opcode patterns and types for the extended op decoder
package ext_decode_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam int LATCH_W = 13;
  localparam int MEM_DEPTH = 4096;

  // ----------------------------------------------------------------
  // register byte offsets on the avalon slave
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0C;
  localparam logic [7:0] REG_PTR0 = 8'h10;
  localparam logic [7:0] REG_PTR1 = 8'h14;
  localparam logic [7:0] REG_PTR2 = 8'h18;
  localparam logic [7:0] REG_PC = 8'h1C;
  localparam logic [7:0] REG_MEM_ADDR = 8'h20;
  localparam logic [7:0] REG_MEM_DATA = 8'h24;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_EXT_BIT = 0;
  localparam int STAT_Z_BIT = 0;
  localparam int STAT_N_BIT = 1;
  localparam logic CFG_EXT_RESET = 1'b0;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  // ----------------------------------------------------------------
  // opcode patterns
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_XOR = 6'h06;
  localparam logic [7:0] OP_PADD = 8'hE8;
  localparam logic [7:0] OP_PSUB = 8'hE9;
  localparam logic [7:0] OP_PUSH = 8'hEA;
  localparam logic [7:0] OP_MOVE = 8'hEB;
  localparam logic [15:0] OP_ICALL = 16'h0014;
  localparam logic [3:0] OP_WORD2 = 4'hF;
  localparam logic [1:0] SEL_PTR2_RET = 2'h3;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;
  localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OPK_NOP, OPK_XOR, OPK_PADD, OPK_PSUB, OPK_PADD_RET, OPK_PSUB_RET,
    OPK_ICALL, OPK_MVABS, OPK_MVOFF, OPK_PUSH
  } op_kind_t;

  typedef enum logic [1:0] {
    ST_RUN, ST_NOP, ST_WORD2
  } core_state_t;

endpackage

// ===== rtl/op_classifier.sv
// op classifier: sorts one instruction word into an operation kind
`timescale 1ns/1ps
`default_nettype none
module op_classifier
  import ext_decode_pkg::*;
(
  // instruction word and mode
  input wire logic [15:0] word,
  input wire logic ext_en,
  // result
  output op_kind_t kind
);

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  // pure decode; disabled extension opcodes fall back to no operation
  always_comb begin
    kind = OPK_NOP;
    if (word[15:10] == OP_XOR) begin
      kind = OPK_XOR;
    end else if (ext_en) begin
      // only these eight kinds are added on top of the base set
      if (word == OP_ICALL) begin
        kind = OPK_ICALL;
      end else begin
        case (word[15:8])
          OP_PADD: kind = (word[7:6] == SEL_PTR2_RET) ? OPK_PADD_RET : OPK_PADD;
          OP_PSUB: kind = (word[7:6] == SEL_PTR2_RET) ? OPK_PSUB_RET : OPK_PSUB;
          OP_PUSH: kind = OPK_PUSH;
          OP_MOVE: kind = word[7] ? OPK_MVOFF : OPK_MVABS;
          default: kind = OPK_NOP;
        endcase
      end
    end
  end

endmodule // op_classifier
`default_nettype wire

// ===== rtl/data_store.sv
// data store: byte array with one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
module data_store
  import ext_decode_pkg::*;
(
  // clock
  input wire logic core_clk,
  input wire logic clk_en,
  // write port
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  // read ports
  input wire logic [ADDR_W-1:0] raddr_a,
  output logic [DATA_W-1:0] rdata_a,
  input wire logic [ADDR_W-1:0] raddr_b,
  output logic [DATA_W-1:0] rdata_b
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [MEM_DEPTH]; // no reset: contents undefined at power up

  // write, frozen with the clock enable
  always_ff @(posedge core_clk) begin
    if (clk_en && we) begin
      mem[waddr] <= wdata;
    end
  end

  // asynchronous reads so a read-modify-write fits one cycle
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule // data_store
`default_nettype wire

// ===== rtl/extended_op_decoder.sv
// extended op decoder: decode and execute of the xor and extension ops
`timescale 1ns/1ps
`default_nettype none
module extended_op_decoder
  import ext_decode_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // instruction stream from program memory
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  // call and return stack side
  input wire logic [PC_W-1:0] stack_top,
  input wire logic [LATCH_W-1:0] pc_latch,
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_addr,
  output logic stack_pop,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------
  // state and wiring
  // ----------------------------------------------------------------
  logic ext_en_r; // extension enable fuse copy
  logic [DATA_W-1:0] acc_r; // accumulator
  logic neg_r; // negative flag
  logic zero_r; // zero flag
  logic [3:0] bank_r; // bank select pointer
  logic [ADDR_W-1:0] ptr_r [3]; // file select pointers
  logic [PC_W-1:0] pc_r; // program counter
  logic [ADDR_W-1:0] mem_addr_r; // software window into data store
  logic [ADDR_W-1:0] src_addr_r; // move source held between words
  logic move_abs_r; // second word is an absolute destination
  core_state_t state_r;
  core_state_t state_nxt;
  logic ready_r;
  logic ready_nxt;
  logic wait_r;
  logic [31:0] rdata_r;
  logic push_r;
  logic [PC_W-1:0] push_addr_r;
  logic pop_r;
  op_kind_t kind; // decoded kind of the word on offer
  logic take; // instruction word accepted this cycle
  logic ack_start; // bus request answered at the next edge
  logic bus_wr; // bus write takes effect at this edge
  logic [31:0] wmerge; // write data merged under byte enables
  logic [7:0] f_fld;
  logic [1:0] sel_fld;
  logic [ADDR_W-1:0] k6;
  logic [ADDR_W-1:0] byte_addr;
  logic [ADDR_W-1:0] ptr2_off; // pointer two plus low seven bits
  logic [ADDR_W-1:0] raddr_a;
  logic [DATA_W-1:0] rdata_a;
  logic [DATA_W-1:0] rdata_b;
  logic [DATA_W-1:0] xor_res;
  logic core_we;
  logic [ADDR_W-1:0] core_waddr;
  logic [DATA_W-1:0] core_wdata;
  logic word2_ok; // second word carries its prefix

  assign f_fld = instr_word[7:0];
  assign sel_fld = instr_word[7:6];
  assign k6 = {6'h00, instr_word[5:0]};
  assign ptr2_off = ptr_r[2] + {5'h00, instr_word[6:0]};
  assign take = instr_valid && ready_r;
  assign ack_start = (avs_read || avs_write) && wait_r;
  assign bus_wr = avs_write && !wait_r;
  assign word2_ok = (instr_word[15:12] == OP_WORD2);
  assign xor_res = acc_r ^ rdata_a;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  op_classifier u_class (
    .word(instr_word),
    .ext_en(ext_en_r),
    .kind(kind)
  );

  data_store u_store (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .we(core_we || (bus_wr && avs_address == REG_MEM_DATA)),
    .waddr(core_we ? core_waddr : mem_addr_r),
    .wdata(core_we ? core_wdata : wmerge[7:0]),
    .raddr_a(raddr_a),
    .rdata_a(rdata_a),
    .raddr_b(mem_addr_r),
    .rdata_b(rdata_b)
  );

  // ----------------------------------------------------------------
  // operand address and data store write
  // ----------------------------------------------------------------
  // byte operand address from access bit and register field
  always_comb begin
    if (instr_word[8]) begin
      byte_addr = {bank_r, f_fld};
    end else if (f_fld <= INDEX_LIMIT) begin
      byte_addr = ext_en_r ? ptr_r[2] + {4'h0, f_fld} : {ACCESS_LOW_PAGE, f_fld};
    end else begin
      byte_addr = {ACCESS_HIGH_PAGE, f_fld};
    end
  end

  // read port a serves the xor operand or the move source
  assign raddr_a = (state_r == ST_WORD2) ? src_addr_r : byte_addr;

  // core writes only happen on a taken word, never in a bus ack cycle
  always_comb begin
    core_we = 1'b0;
    core_waddr = byte_addr;
    core_wdata = xor_res;
    if (take && state_r == ST_WORD2) begin
      core_we = word2_ok;
      core_wdata = rdata_a;
      core_waddr = move_abs_r ? instr_word[11:0] : ptr2_off;
    end else if (take && kind == OPK_XOR) begin
      core_we = instr_word[9];
    end else if (take && kind == OPK_PUSH) begin
      core_we = 1'b1;
      core_waddr = ptr_r[2];
      core_wdata = f_fld;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // next state: two-cycle ops add an idle cycle, moves wait for word two
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (take) begin
          case (kind)
            OPK_PADD_RET, OPK_PSUB_RET, OPK_ICALL: state_nxt = ST_NOP;
            OPK_MVABS, OPK_MVOFF: state_nxt = ST_WORD2;
            default: state_nxt = ST_RUN;
          endcase
        end
      end
      ST_NOP: state_nxt = ST_RUN;
      ST_WORD2: state_nxt = take ? ST_RUN : ST_WORD2;
      default: state_nxt = ST_RUN;
    endcase
    // the idle cycle and the bus ack cycle both refuse words
    ready_nxt = !(state_nxt == ST_NOP || ack_start);
  end

  // state register and instruction ready
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_RUN;
      ready_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
    end
  end

  // move source latched from the first word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_addr_r <= PTR_RESET;
      move_abs_r <= 1'b0;
    end else if (clk_en && take && state_r == ST_RUN &&
                 (kind == OPK_MVABS || kind == OPK_MVOFF)) begin
      src_addr_r <= ptr2_off;
      move_abs_r <= (kind == OPK_MVABS);
    end
  end

  // ----------------------------------------------------------------
  // program counter and stack strobes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= PC_RESET;
      push_r <= 1'b0;
      push_addr_r <= PC_RESET;
      pop_r <= 1'b0;
    end else if (clk_en) begin
      push_r <= 1'b0;
      pop_r <= 1'b0;
      if (take) begin
        if (state_r == ST_RUN && (kind == OPK_PADD_RET || kind == OPK_PSUB_RET)) begin
          pc_r <= stack_top;
          pop_r <= 1'b1;
        end else if (state_r == ST_RUN && kind == OPK_ICALL) begin
          pc_r <= {pc_latch, acc_r};
          push_r <= 1'b1;
          push_addr_r <= pc_r + PC_STEP;
        end else begin
          pc_r <= pc_r + PC_STEP;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  // one pointer per generate entry; software writes land only in ack cycles
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        ptr_r[i] <= PTR_RESET;
      end else if (clk_en) begin
        if (bus_wr && avs_address == REG_PTR0 + 8'(4 * i)) begin
          ptr_r[i] <= wmerge[ADDR_W-1:0];
        end else if (take && state_r == ST_RUN) begin
          if (kind == OPK_PADD && sel_fld == 2'(i)) begin
            ptr_r[i] <= ptr_r[i] + k6;
          end else if (kind == OPK_PSUB && sel_fld == 2'(i)) begin
            ptr_r[i] <= ptr_r[i] - k6;
          end else if (i == 2 && kind == OPK_PADD_RET) begin
            ptr_r[i] <= ptr_r[i] + k6;
          end else if (i == 2 && kind == OPK_PSUB_RET) begin
            ptr_r[i] <= ptr_r[i] - k6;
          end else if (i == 2 && kind == OPK_PUSH) begin
            ptr_r[i] <= ptr_r[i] - 12'h001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // accumulator and status flags
  // ----------------------------------------------------------------
  // extension kinds never reach the flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= ACC_RESET;
      neg_r <= 1'b0;
      zero_r <= 1'b0;
    end else if (clk_en) begin
      if (bus_wr && avs_address == REG_ACC) begin
        acc_r <= wmerge[DATA_W-1:0];
      end else if (take && state_r == ST_RUN && kind == OPK_XOR) begin
        if (!instr_word[9]) begin
          acc_r <= xor_res;
        end
        neg_r <= xor_res[DATA_W-1];
        zero_r <= (xor_res == 8'h00);
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // the fuse copy is cleared at reset, so the extension starts off
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_en_r <= CFG_EXT_RESET;
      bank_r <= BANK_RESET;
      mem_addr_r <= PTR_RESET;
    end else if (clk_en && bus_wr) begin
      case (avs_address)
        REG_CONFIG: ext_en_r <= wmerge[CFG_EXT_BIT];
        REG_BANK: bank_r <= wmerge[3:0];
        REG_MEM_ADDR: mem_addr_r <= wmerge[ADDR_W-1:0];
        default: ;
      endcase
    end
  end

  // merge write data over the current register value by byte lane
  always_comb begin
    logic [31:0] cur;
    cur = 32'h0000_0000;
    case (avs_address)
      REG_ACC: cur = {24'h000000, acc_r};
      REG_BANK: cur = {28'h0000000, bank_r};
      REG_PTR0: cur = {20'h00000, ptr_r[0]};
      REG_PTR1: cur = {20'h00000, ptr_r[1]};
      REG_PTR2: cur = {20'h00000, ptr_r[2]};
      REG_MEM_ADDR: cur = {20'h00000, mem_addr_r};
      REG_MEM_DATA: cur = {24'h000000, rdata_b};
      REG_CONFIG: cur = {31'h00000000, ext_en_r};
      default: cur = 32'h0000_0000;
    endcase
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b +: 8] = avs_byteenable[b] ? avs_writedata[8*b +: 8] : cur[8*b +: 8];
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // every access is answered one cycle after it appears; reads are
  // captured at that decision edge, so they miss a same-edge update
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      wait_r <= !ack_start;
      if (ack_start && avs_read) begin
        case (avs_address)
          REG_CONFIG: rdata_r <= {31'h00000000, ext_en_r};
          REG_ACC: rdata_r <= {24'h000000, acc_r};
          REG_STATUS: rdata_r <= {30'h00000000, neg_r, zero_r};
          REG_BANK: rdata_r <= {28'h0000000, bank_r};
          REG_PTR0: rdata_r <= {20'h00000, ptr_r[0]};
          REG_PTR1: rdata_r <= {20'h00000, ptr_r[1]};
          REG_PTR2: rdata_r <= {20'h00000, ptr_r[2]};
          REG_PC: rdata_r <= {11'h000, pc_r};
          REG_MEM_ADDR: rdata_r <= {20'h00000, mem_addr_r};
          REG_MEM_DATA: rdata_r <= {24'h000000, rdata_b};
          default: rdata_r <= 32'h0000_0000; // unmapped reads as zero
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign instr_ready = ready_r;
  assign stack_push = push_r;
  assign stack_push_addr = push_addr_r;
  assign stack_pop = pop_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

endmodule // extended_op_decoder
`default_nettype wire

// ===== tb/prog_mem_model.sv
// program memory model: offers one instruction word at a time to the decoder
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // word handed in by the bench
  input wire logic go,
  input wire logic [15:0] word_in,
  // fetch handshake
  input wire logic instr_ready,
  output logic instr_valid,
  output logic [15:0] instr_word
);
  // word stays offered until taken; idle word toggles so nothing stale looks valid
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_valid <= 1'b0;
      instr_word <= 16'h0000;
    end else if (instr_valid && instr_ready) begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end else if (go) begin
      instr_valid <= 1'b1;
      instr_word <= word_in;
    end else if (!instr_valid) begin
      instr_word <= ~instr_word;
    end
  end
endmodule // prog_mem_model
`default_nettype wire

// ===== tb/extended_op_decoder_checker.sv
// checker: bus, fetch and stack relations of the extended op decoder
`timescale 1ns/1ps
`default_nettype none
module extended_op_decoder_checker
  import ext_decode_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // fetch side
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  // stack side
  input wire logic stack_push,
  input wire logic [PC_W-1:0] stack_push_addr,
  input wire logic stack_pop,
  // bus side
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // a return variant taken from the stream
  sequence s_take_ret;
    instr_valid && instr_ready && clk_en && instr_word[15:9] == 7'h74 && instr_word[7:6] == SEL_PTR2_RET;
  endsequence
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest;
  endproperty
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_rdata_hold;
    !$stable(avs_readdata) |-> !avs_waitrequest;
  endproperty
  property p_push_cause;
    stack_push |-> $past(instr_valid && instr_ready && clk_en && instr_word == OP_ICALL);
  endproperty
  property p_push_alone;
    stack_push |-> !stack_pop && !instr_ready ##1 !stack_push;
  endproperty
  property p_push_addr;
    !$stable(stack_push_addr) |-> stack_push;
  endproperty
  property p_ret_idle;
    s_take_ret ##1 stack_pop |-> !instr_ready;
  endproperty
  property p_pop_cause;
    stack_pop |-> $past(instr_valid && instr_ready && instr_word[15:9] == 7'h74 && instr_word[7:6] == SEL_PTR2_RET);
  endproperty
  property p_pop_pulse;
    stack_pop |=> !stack_pop;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer not one cycle late");
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  a_rdata_hold: assert property (p_rdata_hold) else $error("readdata moved outside answer");
  a_push_cause: assert property (p_push_cause) else $error("push without call");
  a_push_alone: assert property (p_push_alone) else $error("call push shape wrong");
  a_push_addr: assert property (p_push_addr) else $error("push address moved alone");
  a_ret_idle: assert property (p_ret_idle) else $error("return second cycle busy");
  a_pop_cause: assert property (p_pop_cause) else $error("pop without return op");
  a_pop_pulse: assert property (p_pop_pulse) else $error("pop longer than a cycle");
endmodule // extended_op_decoder_checker
bind extended_op_decoder extended_op_decoder_checker extended_op_decoder_checker_inst (
  .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready), .stack_push(stack_push),
  .stack_push_addr(stack_push_addr), .stack_pop(stack_pop), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// ===== tb/extended_op_decoder_test.sv
// testbench: random and corner stimulus for the extended op decoder
`timescale 1ns/1ps
`default_nettype none
module extended_op_decoder_test;
  import ext_decode_pkg::*;
  // ----------------------------------------------------------------
  // signals and bench state
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic instr_valid, instr_ready, stack_push, stack_pop, avs_waitrequest;
  logic [15:0] instr_word;
  logic [PC_W-1:0] stack_top = 21'h0ABCDE;
  logic [LATCH_W-1:0] pc_latch = 13'h0123;
  logic [PC_W-1:0] stack_push_addr;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic [3:0] be = 4'hF; // byte enables
  int bad_count = 0;
  int compares = 0;
  int seed = 75;
  logic [PC_W-1:0] pc_x = PC_RESET; // expected program counter
  logic [ADDR_W-1:0] p [3]; // expected pointers
  always #12.5 core_clk = ~core_clk;
  extended_op_decoder extended_op_decoder_inst (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(1'b1), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .stack_top(stack_top), .pc_latch(pc_latch),
    .stack_push(stack_push), .stack_push_addr(stack_push_addr), .stack_pop(stack_pop),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  prog_mem_model prog_mem_model_inst (.core_clk(core_clk), .reset_n(reset_n), .go(go),
    .word_in(wd), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_word(instr_word));
  // ----------------------------------------------------------------
  // tasks and expectation functions
  // ----------------------------------------------------------------
  // byte address used by the register xor in each addressing mode
  function automatic logic [11:0] xaddr(int md, logic [3:0] bk, logic [7:0] f, logic [11:0] p2);
    if (md == 0) return {bk, f};
    if (md == 1) return {ACCESS_HIGH_PAGE, f};
    return p2 + 12'(f);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    wr(REG_MEM_ADDR, 32'(a));
    wr(REG_MEM_DATA, 32'(d));
  endtask
  task automatic mr(input logic [11:0] a, input logic [7:0] e, input string nm);
    wr(REG_MEM_ADDR, 32'(a));
    rc(REG_MEM_DATA, 32'(e), nm);
  endtask
  // hand one word to the model, wait until taken, let two-cycle ops finish
  task automatic ins(input logic [15:0] w);
    @(posedge core_clk);
    go <= 1'b1;
    wd <= w;
    @(posedge core_clk);
    go <= 1'b0;
    do @(posedge core_clk); while (instr_valid !== 1'b0);
    repeat (2) @(posedge core_clk);
    pc_x = pc_x + PC_STEP;
  endtask
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    #(25 * 40000);
    bad_count++;
    results();
  end
  initial begin
    logic [7:0] a, m, f, r, fl;
    logic [3:0] bk;
    logic [5:0] k;
    logic [11:0] ad;
    logic [PC_W-1:0] t;
    int md, idx;
    p = '{default: PTR_RESET};
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    rc(REG_CONFIG, 32'h0, "config");
    rc(REG_PTR2, 32'h0, "ptr2");
    rc(REG_PC, 32'h0, "pc");
    rc(8'h40, 32'h0, "unmapped");
    // extension words with the fuse clear only step the pc
    ins(16'hE823);
    ins(16'hEB05);
    ins(16'hF234);
    rc(REG_PTR0, 32'h0, "ptr0 off");
    rc(REG_PC, 32'(pc_x), "pc off");
    wr(REG_CONFIG, 32'h1);
    // nonzero pointer two so indexed and low page addresses differ
    wr(REG_PTR2, 32'h300);
    p[2] = 12'h300;
    // xor through bank, access and indexed paths, destination alternating
    for (int i = 0; i < 6; i++) begin
      a = 8'($random(seed));
      m = (i == 3) ? a : 8'($random(seed));
      f = 8'($random(seed));
      bk = 4'($random(seed));
      md = i % 3;
      if (md == 1) f[7] = 1'b1;
      if (md == 2) f = f % 8'h60;
      ad = xaddr(md, bk, f, p[2]);
      wr(REG_BANK, 32'(bk));
      wr(REG_ACC, 32'(a));
      mw(ad, m);
      ins({OP_XOR, i[0], md == 0, f});
      r = a ^ m;
      fl = {6'h00, r[7], r == 8'h00};
      rc(REG_ACC, 32'(i[0] ? a : r), "xor acc");
      mr(ad, i[0] ? r : m, "xor reg");
      rc(REG_STATUS, 32'(fl), "xor flags");
    end
    // pointer add and subtract, every select value, return variants included
    for (int i = 0; i < 8; i++) begin
      k = 6'($random(seed));
      idx = (i % 4 == 3) ? 2 : i % 4;
      stack_top <= 21'($random(seed));
      ins({7'h74, i[2], 2'(i % 4), k});
      p[idx] = i[2] ? p[idx] - 12'(k) : p[idx] + 12'(k);
      if (i % 4 == 3) pc_x = stack_top;
      rc(REG_PTR0 + 8'(idx * 4), 32'(p[idx]), "pointer");
      rc(REG_PC, 32'(pc_x), "pc");
      rc(REG_STATUS, 32'(fl), "flags kept");
    end
    // push literal at pointer zero wraps the pointer
    wr(REG_PTR2, 32'h0);
    a = 8'($random(seed));
    ins({8'hEA, a});
    mr(12'h000, a, "push data");
    rc(REG_PTR2, 32'hFFF, "push ptr");
    // both moves, second word of the offset form with ignored bits set
    wr(REG_PTR2, 32'h100);
    m = 8'($random(seed));
    mw(12'h105, m);
    ins(16'hEB05);
    ins(16'hF234);
    mr(12'h234, m, "move abs");
    m = 8'($random(seed));
    mw(12'h110, m);
    ins(16'hEB90);
    ins(16'hF5A0);
    mr(12'h120, m, "move off");
    rc(REG_PC, 32'(pc_x), "pc moves");
    // call through the accumulator
    a = 8'($random(seed));
    wr(REG_ACC, 32'(a));
    // lane 0 masked: the accumulator must keep its value
    be <= 4'hE;
    wr(REG_ACC, 32'hFF);
    be <= 4'hF;
    pc_latch <= 13'($random(seed));
    ins(OP_ICALL);
    t = pc_x;
    pc_x = {pc_latch, a};
    rc(REG_PC, 32'(pc_x), "call pc");
    chk("push addr", 32'(stack_push_addr), 32'(t));
    rc(REG_STATUS, 32'(fl), "flags kept");
    results();
  end
endmodule // extended_op_decoder_test
`default_nettype wire
